// File: src/crs_call_return.sv
// Decode and execute logic for push, relative call, soft reset and returns.
// Operation
// - Stack save pushes PC plus two
// - Relative call opcode starts with 11011
// - Call offset is signed, -1024 to 1023
// - Call pushes PC plus two first
// - Call then jumps to PC+2+2n
// - Soft reset clears all core state but run and the sticky event flags
// - Interrupt return pops PC, sets enable
// - Fast bit restores shadows, else untouched
// - Interrupt return opcode ends in 000s
// - Interrupt return keeps PC latches unchanged
// - Literal return loads W and pops PC
// - Literal return opcode upper byte 00001100
`timescale 1ns/1ps
module crs_call_return
  import crs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Instruction fetch
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic instr_valid_i,
  output logic [PC_W-1:0] fetch_addr_o,
  output logic instr_ack_o,
  // Core events
  output logic soft_reset_o
);
  crs_stack_if stk (); // Return stack link

  crs_return_stack u_stack (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .stk(stk)
  );

  // Core state
  crs_phase_e phase; // Quarter phase within the cycle
  crs_op_e op; // Decoded kind of the held instruction
  logic [INSTR_W-1:0] ir; // Held instruction word
  logic flush; // Current cycle is a forced no-operation
  logic run; // Software lets the core execute
  logic [PC_W-1:0] pc; // Program counter
  logic [DATA_W-1:0] work; // Working register
  logic [DATA_W-1:0] flags; // Status flags
  logic [DATA_W-1:0] bank_select_reg; // Bank select
  logic [DATA_W-1:0] working_shadow; // Shadow of working register
  logic [DATA_W-1:0] flags_shadow; // Shadow of the flags
  logic [DATA_W-1:0] bank_select_shadow; // Shadow of bank select
  logic high_priority_int_enable; // Global high priority enable
  logic low_priority_int_enable; // Global low priority enable
  logic [DATA_W-1:0] pc_high_latch; // Staged high PC byte
  logic [LATCH_U_W-1:0] pc_upper_latch; // Staged upper PC bits
  logic srst_seen; // Sticky: soft reset happened
  logic undef_seen; // Sticky: an unknown opcode ran as no-operation

  // Decode helpers
  logic active; // Core advances this cycle
  logic exec_q2; // Q2 of a real instruction
  logic exec_q4; // Q4 of a real instruction
  logic soft_clr; // Soft reset takes effect now
  logic fast; // Shadow restore bit of the held word
  logic [PC_W-1:0] pc_next_seq; // Address after this word
  logic [PC_W-1:0] call_ofs; // Offset times two, sign extended
  crs_op_e next_op; // Decode of the incoming word
  logic known_op; // Incoming word is one of this group or the all-zero filler

  // Bus helpers
  logic bus_acc; // Access phase, answer not yet given
  logic bus_wr; // Write completes at this edge
  logic bus_ok; // Core state may be written by software
  logic [31:0] next_rdata; // Read value for the current address
  logic next_err; // Address is not mapped

  // The core only starts a new word when running, but always finishes one
  assign active = run || (phase != PH_Q1);
  assign exec_q2 = active && (phase == PH_Q2) && !flush;
  assign exec_q4 = active && (phase == PH_Q4) && !flush;
  assign soft_clr = exec_q4 && (op == OP_SRST);
  assign fast = ir[0];
  assign pc_next_seq = pc + PC_STEP;
  // Eleven-bit two's complement offset doubled, so -1024..1023 words reach
  // Doubling keeps every target on an even byte address, where all words start
  assign call_ofs = {{(PC_W-CALL_OFS_W-1){ir[CALL_OFS_W-1]}}, ir[CALL_OFS_W-1:0], 1'b0};

  // Instruction decode of the word offered at Q1
  always_comb begin
    next_op = OP_NOP;
    known_op = 1'b1;
    if (instr_i == OPC_PUSH) begin
      next_op = OP_PUSH;
    end else if (instr_i[15:11] == OPC_CALL_TOP) begin
      next_op = OP_CALL;
    end else if (instr_i == OPC_SOFT_RESET) begin
      next_op = OP_SRST;
    end else if (instr_i[15:1] == OPC_IRET_TOP) begin
      next_op = OP_IRET;
    end else if (instr_i[15:8] == OPC_LRET_TOP) begin
      next_op = OP_LRET;
    end else begin
      // The all-zero word is the idle filler, so it is not counted as unknown
      known_op = (instr_i == '0);
    end
  end

  // Quarter phase sequencer; Q1 waits for a word unless flushing
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || soft_clr) begin
      phase <= PH_Q1;
    end else if (active) begin
      case (phase)
        PH_Q1: begin
          if (flush || instr_valid_i) begin
            phase <= PH_Q2;
          end
        end
        PH_Q2: phase <= PH_Q3;
        PH_Q3: phase <= PH_Q4;
        PH_Q4: phase <= PH_Q1;
        default: phase <= PH_Q1;
      endcase
    end
  end

  // Instruction register, loaded at Q1 of a non-flush cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || soft_clr) begin
      ir <= '0;
      op <= OP_NOP;
    end else if (run && phase == PH_Q1 && !flush && instr_valid_i) begin
      ir <= instr_i;
      op <= next_op;
    end
  end

  // Fetch handshake pulse, one cycle after the word was taken
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      instr_ack_o <= 1'b0;
    end else begin
      instr_ack_o <= run && (phase == PH_Q1) && !flush && instr_valid_i && !soft_clr;
    end
  end

  // Flush flag: a taken branch wastes the next cycle while the target is fetched
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || soft_clr) begin
      flush <= 1'b0;
    end else if (active && phase == PH_Q4) begin
      // The opcode is held through the flush, so !flush ends it after one cycle
      flush <= !flush && (op == OP_CALL || op == OP_IRET || op == OP_LRET);
    end
  end

  // Stack requests: pushes in Q2, pops in Q4
  always_comb begin
    // Push and pop never meet in one cycle, as they live in different phases
    stk.push = exec_q2 && (op == OP_PUSH || op == OP_CALL);
    stk.push_data = pc_next_seq;
    stk.pop = exec_q4 && (op == OP_IRET || op == OP_LRET);
    stk.clr = soft_clr;
    stk.flag_clr = '0;
    if (bus_wr && paddr_i == ADDR_STACK) begin
      stk.flag_clr = {pwdata_i[STK_UNF_BIT], pwdata_i[STK_OVF_BIT]};
    end
  end

  // Program counter; the call target is formed after the push in Q2
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || soft_clr) begin
      pc <= PC_RST;
    end else if (exec_q4) begin
      case (op)
        OP_CALL: pc <= pc_next_seq + call_ofs;
        // The top is read here before the pop at this same edge moves it
        OP_IRET: pc <= stk.top;
        OP_LRET: pc <= stk.top;
        default: pc <= pc_next_seq;
      endcase
    end else if (bus_ok && bus_wr && paddr_i == ADDR_PC) begin
      pc <= {pwdata_i[PC_W-1:1], 1'b0};
    end
  end

  // Working, flags and bank select: literal load or shadow restore
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || soft_clr) begin
      work <= BYTE_RST;
      flags <= BYTE_RST;
      bank_select_reg <= BYTE_RST;
    end else if (exec_q4 && op == OP_LRET) begin
      work <= ir[7:0];
    end else if (exec_q4 && op == OP_IRET) begin
      if (fast) begin
        work <= working_shadow;
        flags <= flags_shadow;
        bank_select_reg <= bank_select_shadow;
      end
    // Software writes land only on a halted core and are dropped otherwise, so they never race an instruction
    end else if (bus_ok && bus_wr) begin
      case (paddr_i)
        ADDR_WORK: work <= pwdata_i[DATA_W-1:0];
        ADDR_FLAGS: flags <= pwdata_i[DATA_W-1:0];
        ADDR_BANK: bank_select_reg <= pwdata_i[DATA_W-1:0];
        default: ;
      endcase
    end
  end

  // Shadow copies, loaded only by software in this block
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || soft_clr) begin
      working_shadow <= BYTE_RST;
      flags_shadow <= BYTE_RST;
      bank_select_shadow <= BYTE_RST;
    end else if (bus_ok && bus_wr && paddr_i == ADDR_SHADOW) begin
      working_shadow <= pwdata_i[7:0];
      flags_shadow <= pwdata_i[15:8];
      bank_select_shadow <= pwdata_i[23:16];
    end
  end

  // Global enables; the return sets high first, low if high is already on
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || soft_clr) begin
      high_priority_int_enable <= 1'b0;
      low_priority_int_enable <= 1'b0;
    end else if (exec_q4 && op == OP_IRET) begin
      if (!high_priority_int_enable) begin
        high_priority_int_enable <= 1'b1;
      end else begin
        low_priority_int_enable <= 1'b1;
      end
    end else if (bus_wr && paddr_i == ADDR_INTEN) begin
      high_priority_int_enable <= pwdata_i[INT_HIGH_BIT];
      low_priority_int_enable <= pwdata_i[INT_LOW_BIT];
    end
  end

  // PC latches: no instruction of this group writes them except soft reset, which clears them
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || soft_clr) begin
      pc_high_latch <= BYTE_RST;
      pc_upper_latch <= LATCH_U_RST;
    end else if (bus_wr && paddr_i == ADDR_LATCH) begin
      pc_high_latch <= pwdata_i[7:0];
      pc_upper_latch <= pwdata_i[8+LATCH_U_W-1:8];
    end
  end

  // Run control survives a soft reset so software keeps command of the core
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      run <= 1'b0;
    end else if (bus_wr && paddr_i == ADDR_CTRL) begin
      run <= pwdata_i[CTRL_RUN_BIT];
    end
  end

  // Sticky event flags; a new event wins over a write-one clear
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      srst_seen <= 1'b0;
      undef_seen <= 1'b0;
    end else begin
      srst_seen <= soft_clr ||
        (srst_seen && !(bus_wr && paddr_i == ADDR_CTRL && pwdata_i[CTRL_SRST_BIT]));
      undef_seen <= (run && phase == PH_Q1 && !flush && instr_valid_i && !known_op) ||
        (undef_seen && !(bus_wr && paddr_i == ADDR_CTRL && pwdata_i[CTRL_UNDEF_BIT]));
    end
  end

  // Registered outputs toward the core
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      soft_reset_o <= 1'b0;
      fetch_addr_o <= PC_RST;
    end else begin
      soft_reset_o <= soft_clr;
      fetch_addr_o <= soft_clr ? PC_RST : pc;
    end
  end

  // Bus timing: one wait state, the write lands at the edge that sees pready
  assign bus_acc = psel_i && penable_i && !pready_o;
  assign bus_wr = psel_i && penable_i && pwrite_i && pready_o && !pslverr_o;
  // Core state except run, sticky flags, enables and latches is only written while halted between instructions
  assign bus_ok = !run && (phase == PH_Q1) && !flush;

  // Read mux and address decode
  always_comb begin
    next_rdata = '0;
    next_err = 1'b0;
    case (paddr_i)
      ADDR_CTRL: begin
        next_rdata[CTRL_RUN_BIT] = run;
        next_rdata[CTRL_SRST_BIT] = srst_seen;
        next_rdata[CTRL_UNDEF_BIT] = undef_seen;
      end
      ADDR_PC: next_rdata[PC_W-1:0] = pc;
      ADDR_WORK: next_rdata[DATA_W-1:0] = work;
      ADDR_FLAGS: next_rdata[DATA_W-1:0] = flags;
      ADDR_BANK: next_rdata[DATA_W-1:0] = bank_select_reg;
      ADDR_SHADOW: next_rdata[23:0] = {bank_select_shadow, flags_shadow, working_shadow};
      ADDR_INTEN: begin
        next_rdata[INT_HIGH_BIT] = high_priority_int_enable;
        next_rdata[INT_LOW_BIT] = low_priority_int_enable;
      end
      ADDR_LATCH: next_rdata[8+LATCH_U_W-1:0] = {pc_upper_latch, pc_high_latch};
      ADDR_STACK: begin
        next_rdata[SP_W-1:0] = stk.depth;
        next_rdata[STK_OVF_BIT] = stk.ovf;
        next_rdata[STK_UNF_BIT] = stk.unf;
        next_rdata[31:11] = stk.top;
      end
      default: next_err = 1'b1;
    endcase
  end

  // Bus answer registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end else begin
      pready_o <= bus_acc;
      pslverr_o <= bus_acc && next_err;
      prdata_o <= (bus_acc && !pwrite_i) ? next_rdata : 32'h00000000;
    end
  end
endmodule : crs_call_return

// File: src/crs_pkg.sv
// Shared constants and types for the call and return instruction group.
package crs_pkg;
  // Widths of the core state this block works on
  localparam int PC_W = 21;
  localparam int INSTR_W = 16;
  localparam int DATA_W = 8;
  localparam int STACK_DEPTH = 31;
  localparam int SP_W = 5;
  localparam int LATCH_U_W = 5;
  localparam int APB_AW = 8;

  // Opcode patterns
  localparam logic [INSTR_W-1:0] OPC_PUSH = 16'h0005;
  localparam logic [INSTR_W-1:0] OPC_SOFT_RESET = 16'h00ff;
  localparam logic [4:0] OPC_CALL_TOP = 5'h1b;
  localparam logic [14:0] OPC_IRET_TOP = 15'h0008;
  localparam logic [7:0] OPC_LRET_TOP = 8'h0c;
  localparam int CALL_OFS_W = 11;

  // Byte addresses of the registers on the bus
  localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_PC = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_WORK = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_FLAGS = 8'h0c;
  localparam logic [APB_AW-1:0] ADDR_BANK = 8'h10;
  localparam logic [APB_AW-1:0] ADDR_SHADOW = 8'h14;
  localparam logic [APB_AW-1:0] ADDR_INTEN = 8'h18;
  localparam logic [APB_AW-1:0] ADDR_LATCH = 8'h1c;
  localparam logic [APB_AW-1:0] ADDR_STACK = 8'h20;

  // Field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SRST_BIT = 8;
  localparam int CTRL_UNDEF_BIT = 9;
  localparam int STK_OVF_BIT = 8;
  localparam int STK_UNF_BIT = 9;
  localparam int INT_HIGH_BIT = 0;
  localparam int INT_LOW_BIT = 1;

  // Values after reset
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
  localparam logic [LATCH_U_W-1:0] LATCH_U_RST = 5'h00;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

  // Quarter phases of one instruction cycle
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} crs_phase_e;

  // Decoded instruction kinds
  typedef enum logic [2:0] {
    OP_NOP, OP_PUSH, OP_CALL, OP_SRST, OP_IRET, OP_LRET
  } crs_op_e;
endpackage : crs_pkg

// File: src/crs_return_stack.sv
// Hardware return stack holding return addresses.
`timescale 1ns/1ps
module crs_return_stack
  import crs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Link to the instruction logic
  crs_stack_if.stack stk
);
  logic [PC_W-1:0] mem [STACK_DEPTH]; // Entry storage
  logic [SP_W-1:0] depth; // Fill level
  logic full; // No room for a push
  logic empty; // Nothing to pop

  assign full = (depth == SP_W'(STACK_DEPTH));
  assign empty = (depth == '0);

  // Fill level moves by one per push or pop; a push beyond full is dropped
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || stk.clr) begin
      depth <= '0;
    end else if (stk.push && !full) begin
      depth <= depth + 5'h01;
    end else if (stk.pop && !empty) begin
      depth <= depth - 5'h01;
    end
  end

  // Entry write; storage needs no reset since depth guards every read
  always_ff @(posedge ref_clk_i) begin
    if (stk.push && !full) begin
      mem[depth] <= stk.push_data;
    end
  end

  // Sticky error flags; a new error wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || stk.clr) begin
      stk.ovf <= 1'b0;
      stk.unf <= 1'b0;
    end else begin
      stk.ovf <= (stk.push && full) || (stk.ovf && !stk.flag_clr[0]);
      stk.unf <= (stk.pop && empty) || (stk.unf && !stk.flag_clr[1]);
    end
  end

  // An empty stack reads as address zero
  assign stk.top = empty ? PC_RST : mem[depth - 5'h01];
  assign stk.depth = depth;
endmodule : crs_return_stack

// File: src/crs_stack_if.sv
// Connection between the instruction logic and the return stack.
`timescale 1ns/1ps
interface crs_stack_if;
  import crs_pkg::*;
  logic push; // Push request, one cycle
  logic pop; // Pop request, one cycle
  logic clr; // Empty the stack, one cycle
  logic [PC_W-1:0] push_data; // Address to push
  logic [1:0] flag_clr; // Clear overflow / underflow flags
  logic [PC_W-1:0] top; // Current top entry
  logic [SP_W-1:0] depth; // Number of entries held
  logic ovf; // Sticky overflow
  logic unf; // Sticky underflow

  modport cpu (output push, pop, clr, push_data, flag_clr, input top, depth, ovf, unf);
  modport stack (input push, pop, clr, push_data, flag_clr, output top, depth, ovf, unf);
endinterface : crs_stack_if

// File: test/crs_call_return_chk.sv
// Port-level assertions for the call and return instruction block.
`timescale 1ns/1ps
module crs_call_return_chk
  import crs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // APB side
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Fetch side
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic [PC_W-1:0] fetch_addr_o,
  input wire logic instr_ack_o,
  input wire logic soft_reset_o
);
  // One clock domain, so one default for all
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // Two-cycle kinds get a flush cycle after them
  function automatic logic two_cyc(input logic [INSTR_W-1:0] op);
    return op[15:11] == OPC_CALL_TOP || op[15:1] == OPC_IRET_TOP || op[15:8] == OPC_LRET_TOP;
  endfunction : two_cyc

  // PC lands one fetch copy later
  sequence s_pc_cleared;
    ##1 fetch_addr_o == PC_RST;
  endsequence

  // Bus handshake
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("pready held");
  a_ready_cause: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("access not answered");
  a_ready_access: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("pready without access");
  a_err_ready: assert property (pslverr_o |-> pready_o) else $error("pslverr alone");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h00000000)
    else $error("rdata not zero");
  // Fetch and execution
  a_ack_cause: assert property (instr_ack_o |-> $past(instr_valid_i)) else $error("ack alone");
  a_ack_gap: assert property (instr_ack_o |=> !instr_ack_o [*3]) else $error("cycle short");
  a_flush_gap: assert property (instr_ack_o && two_cyc($past(instr_i)) |=>
    !instr_ack_o [*7]) else $error("flush cycle missing");
  a_srst_when: assert property (soft_reset_o |-> $past(instr_ack_o, 3) &&
    $past(instr_i, 4) == OPC_SOFT_RESET) else $error("soft reset timing");
  a_srst_pc: assert property (soft_reset_o |-> s_pc_cleared) else $error("pc not cleared");
  a_push_pc: assert property (instr_ack_o && $past(instr_i) == OPC_PUSH |->
    ##4 fetch_addr_o == $past(fetch_addr_o, 4) + PC_STEP) else $error("push pc step");
  a_call_pc: assert property (instr_ack_o && $past(instr_i[15:11]) == OPC_CALL_TOP |->
    ##4 fetch_addr_o == $past(fetch_addr_o, 4) + PC_STEP
    + {{9{$past(instr_i[10], 5)}}, $past(instr_i[10:0], 5), 1'b0}) else $error("call target");
endmodule : crs_call_return_chk

// File: test/crs_call_return_tb.sv
// Self-checking bench for the call and return instruction block.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module crs_call_return_tb;
  import crs_pkg::*;
  // Design stimulus, all driven from time zero
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [APB_AW-1:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [INSTR_W-1:0] instr_i = 16'h0000;
  logic instr_valid_i = 1'b0;
  // Design outputs
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [PC_W-1:0] fetch_addr_o;
  logic instr_ack_o;
  logic soft_reset_o;
  // Expected core state
  logic [PC_W-1:0] e_pc = 21'h000000;
  logic [PC_W-1:0] stk[$];
  logic [7:0] e_w, e_fl, e_bank;
  logic [23:0] e_sh;
  logic [1:0] e_en;
  logic [12:0] e_lat;
  int error_cnt = 0;
  int n_checks = 0;
  int seed = 78726;

  crs_call_return dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .fetch_addr_o(fetch_addr_o), .instr_ack_o(instr_ack_o),
    .soft_reset_o(soft_reset_o));

  // 100 ns clock
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  // Counts, verdict and end of run
  task automatic final_report();
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int k;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge ref_clk_i);
      if (pready_o === 1'b1) break;
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (k == 40) begin
      error_cnt++;
      final_report();
    end
  endtask : apb

  // Return address plus twice the signed offset
  function automatic logic [PC_W-1:0] tgt(input logic [PC_W-1:0] pc, input logic [10:0] n);
    return pc + PC_STEP + {{9{n[10]}}, n, 1'b0};
  endfunction : tgt

  // Reference behaviour of one instruction
  task automatic model(input logic [15:0] op);
    logic [PC_W-1:0] nxt;
    nxt = e_pc + PC_STEP;
    if (op == OPC_PUSH) begin
      stk.push_back(nxt);
      e_pc = nxt;
    end else if (op[15:11] == OPC_CALL_TOP) begin
      stk.push_back(nxt);
      e_pc = tgt(e_pc, op[10:0]);
    end else if (op[15:1] == OPC_IRET_TOP) begin
      e_pc = stk.pop_back();
      // High enable first, low once high is set
      if (!e_en[0]) e_en[0] = 1'b1;
      else e_en[1] = 1'b1;
      if (op[0]) {e_bank, e_fl, e_w} = e_sh;
    end else if (op[15:8] == OPC_LRET_TOP) begin
      e_pc = stk.pop_back();
      e_w = op[7:0];
    end else if (op == OPC_SOFT_RESET) begin
      e_pc = PC_RST;
      stk.delete();
      {e_w, e_fl, e_bank, e_sh, e_en, e_lat} = '0;
    end else begin
      e_pc = nxt;
    end
  endtask : model

  // Offer a word, wait for the ack, let the instruction finish
  task automatic exec(input logic [15:0] op);
    int k;
    logic sr;
    sr = 1'b0;
    @(posedge ref_clk_i);
    instr_i <= op;
    instr_valid_i <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge ref_clk_i);
      if (instr_ack_o === 1'b1) break;
    end
    instr_valid_i <= 1'b0;
    if (k == 40) begin
      error_cnt++;
      final_report();
    end
    // Covers the flush cycle of the two-cycle kinds
    repeat (9) begin
      @(posedge ref_clk_i);
      if (soft_reset_o === 1'b1) sr = 1'b1;
    end
    `CHK(sr, op == OPC_SOFT_RESET)
    model(op);
  endtask : exec

  // Read back the core state and compare with the model
  task automatic check_state();
    logic [31:0] d;
    logic er;
    apb(1'b0, ADDR_PC, 32'h0, d, er);
    `CHK(d[20:0], e_pc)
    `CHK(fetch_addr_o, e_pc)
    apb(1'b0, ADDR_STACK, 32'h0, d, er);
    `CHK(d[4:0], stk.size())
    if (stk.size() > 0) `CHK(d[31:11], stk[$])
    apb(1'b0, ADDR_WORK, 32'h0, d, er);
    `CHK(d[7:0], e_w)
    apb(1'b0, ADDR_FLAGS, 32'h0, d, er);
    `CHK(d[7:0], e_fl)
    apb(1'b0, ADDR_BANK, 32'h0, d, er);
    `CHK(d[7:0], e_bank)
    apb(1'b0, ADDR_SHADOW, 32'h0, d, er);
    `CHK(d[23:0], e_sh)
    apb(1'b0, ADDR_INTEN, 32'h0, d, er);
    `CHK(d[1:0], e_en)
    apb(1'b0, ADDR_LATCH, 32'h0, d, er);
    `CHK(d[12:0], e_lat)
  endtask : check_state

  // Main sequence
  initial begin
    logic [31:0] d, r;
    logic er;
    logic [15:0] op;
    logic [15:0] fixed[7];
    // Corner offsets, both return kinds, and an unknown word
    fixed = '{16'hdbff, 16'hdc00, 16'h0005, 16'h0010, 16'h0011, 16'h0c5a, 16'h1234};
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    apb(1'b0, ADDR_CTRL, 32'h0, d, er);
    `CHK(d, 32'h00000000)
    // Unmapped place is refused with zero data
    apb(1'b0, 8'h40, 32'h0, d, er);
    `CHK({er, d}, 33'h100000000)
    `CHK(er, 1'b1)
    // Preload core state while stopped
    r = $random(seed);
    {e_w, e_fl, e_bank, e_en} = {r[23:0], 2'b00};
    e_sh = 24'h5a3cc3;
    e_lat = r[31:19];
    apb(1'b1, ADDR_WORK, {24'h0, e_w}, d, er);
    apb(1'b1, ADDR_FLAGS, {24'h0, e_fl}, d, er);
    apb(1'b1, ADDR_BANK, {24'h0, e_bank}, d, er);
    apb(1'b1, ADDR_SHADOW, {8'h0, e_sh}, d, er);
    apb(1'b1, ADDR_LATCH, {19'h0, e_lat}, d, er);
    apb(1'b1, ADDR_INTEN, 32'h0, d, er);
    check_state();
    apb(1'b1, ADDR_CTRL, 32'h00000001, d, er);
    foreach (fixed[i]) begin
      exec(fixed[i]);
      check_state();
    end
    // Random mix that keeps the stack within its depth
    repeat (30) begin
      r = $random(seed);
      case (r[1:0])
        2'd0: op = OPC_PUSH;
        2'd1: op = {OPC_CALL_TOP, r[12:2]};
        2'd2: op = {OPC_LRET_TOP, r[9:2]};
        default: op = {OPC_IRET_TOP, r[2]};
      endcase
      if (op[15:11] != OPC_CALL_TOP && op != OPC_PUSH && stk.size() == 0) op = OPC_PUSH;
      if (op[15:11] == OPC_CALL_TOP && stk.size() == 31) op = {OPC_LRET_TOP, r[9:2]};
      if (op == OPC_PUSH && stk.size() == 31) op = {OPC_LRET_TOP, r[9:2]};
      exec(op);
      check_state();
    end
    // Software reset clears core state but keeps run
    exec(OPC_SOFT_RESET);
    check_state();
    apb(1'b0, ADDR_CTRL, 32'h0, d, er);
    `CHK({d[9:8], d[0]}, 3'b111)
    final_report();
  end
endmodule : crs_call_return_tb

bind crs_call_return crs_call_return_chk u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .instr_i(instr_i), .instr_valid_i(instr_valid_i), .fetch_addr_o(fetch_addr_o),
  .instr_ack_o(instr_ack_o), .soft_reset_o(soft_reset_o));
